/* File: design/ee_defines.svh */
/*
  Constants for the three-wire serial memory slave: command codes, frame
  lengths, timing figures and pin-facing options.
  Assumes a 100 MHz system clock and a link clock that runs only in frames.
*/
// Overview of operation
// - Respond only while select is high.
// - Ignore serial input while deselected.
// - Output floats while deselected.
// - Input bits sampled on rising link clock.
// - Read bits shifted out after rising edge.
// - Show ready/busy after qualified reselect.
// - Strap high selects sixteen-bit words.
// - Strap low selects eight-bit words.
// - Floating strap defaults to sixteen-bit words.
// - 1024 bits: 128x8 or 64x16.
// - Fixed variant ignores strap, always 64x16.
// - Programming self-timed, at most five milliseconds.
// - Read decodes address, then sends word.
// - Program only while unlock state set.
// - Write overwrites word without erase.
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

// Command codes following the start bit
`define EE_OP_SPECIAL    2'h0
`define EE_OP_WRITE      2'h1
`define EE_OP_READ       2'h2
`define EE_OP_ERASE      2'h3
// Sub-codes in the top two address bits of a special command
`define EE_SUB_UNLOCK    2'h3
`define EE_SUB_LOCK      2'h0

// Last bit index of header (opcode plus address) and of data
`define EE_HDR_LAST_X16  5'h07
`define EE_HDR_LAST_X8   5'h08
`define EE_DAT_LAST_X16  5'h0F
`define EE_DAT_LAST_X8   5'h07
// Word lengths shifted out on a read
`define EE_BITS_X16      5'h10
`define EE_BITS_X8       5'h08
// Dummy link clocks between address and first data bit
`define EE_GAP_LAST      5'h07

// Timing figures
`define EE_CLK_MHZ       100
`define EE_PROG_TIME_MS  5
`define EE_DESEL_TIME_NS 250
`define EE_DESEL_CYC     ((`EE_DESEL_TIME_NS * `EE_CLK_MHZ + 999) / 1000)
`define EE_PROG_CYC      (`EE_PROG_TIME_MS * 1000 * 1000 * `EE_CLK_MHZ / 1000)

// Erase pattern and misc widths
`define EE_ERASED_WORD   16'hFFFF
`define EE_ZERO_WORD     16'h0000
`define EE_ZERO_BYTE     8'h00
`define EE_BYTE_LO       2'h1
`define EE_BYTE_HI       2'h2
`define EE_BYTE_BOTH     2'h3
`define EE_FIFO_DEPTH    2'h2

`endif

/* File: design/ee_pkg.sv */
/*
  Types shared by the link-clock and system-clock sides of the serial memory slave.
  Assumes ee_defines.svh supplies all numeric constants.
*/
package ee_pkg;

  // Link-side frame sequencer, one-hot
  typedef enum logic [5:0] {
    EE_LS_IDLE = 6'h01,
    EE_LS_HEAD = 6'h02,
    EE_LS_DATA = 6'h04,
    EE_LS_GAP  = 6'h08,
    EE_LS_READ = 6'h10,
    EE_LS_DONE = 6'h20
  } ee_link_state_t;

  // System-side command engine, one-hot
  typedef enum logic [3:0] {
    EE_ES_IDLE  = 4'h1,
    EE_ES_RWAIT = 4'h2,
    EE_ES_RTAKE = 4'h4,
    EE_ES_PROG  = 4'h8
  } ee_eng_state_t;

  // One decoded command as it crosses to the system clock
  typedef struct packed {
    logic [1:0]  op;
    logic        x8;
    logic [6:0]  addr;
    logic [15:0] data;
  } ee_cmd_t;

endpackage

/* File: design/ee_word_mem.sv */
/*
  Word store: 64 words of 16 bits with byte write enables, read data
  registered one cycle after the address.
  Assumes one synchronous write port and one read port on clk_sys.
*/
`timescale 1ns/100ps
`include "ee_defines.svh"

module ee_word_mem (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        wrEn,
  input  wire logic [1:0]  byteEn,
  input  wire logic [5:0]  addr,
  input  wire logic [15:0] wrData,
  output logic      [15:0] rdData
);

  // Byte-lane storage, one generate per lane; each lane owns its array so no
  // array is written from two processes; a write simply replaces the lane
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      // Lane storage; contents survive reset, as a nonvolatile array would
      logic [7:0] cells [0:63];

      // Lane write
      always_ff @(posedge clk_sys) begin
        if (wrEn && byteEn[lane]) begin
          cells[addr] <= wrData[lane*8 +: 8];
        end
      end

      // Registered read of this lane
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          rdData[lane*8 +: 8] <= `EE_ZERO_BYTE;
        end else begin
          rdData[lane*8 +: 8] <= cells[addr];
        end
      end
    end
  endgenerate

endmodule

/* File: design/ee_serial_slave.sv */
/*
  Three-wire serial memory slave: link-clock frame decoder, two-entry
  command buffer, self-timed programming engine and pin output stage.
  Assumes the master drives select, link clock and serial input, and that
  the link clock stands still outside frames.
*/
`timescale 1ns/100ps
`include "ee_defines.svh"

module ee_serial_slave #(
  parameter bit          FIXED_X16   = 1'b0,          // Variant without strap
  parameter int unsigned PROG_CYCLES = `EE_PROG_CYC   // Programming time in clk_sys cycles
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic serial_shift_clock,
  input  wire logic linkSel,
  input  wire logic serial_in_pin,
  input  wire logic word_width_strap,
  output logic      dataOut,
  output logic      dataOutEn,
  output logic      progBusy
);

  // Link-clock frame state, cleared whenever the frame ends
  typedef struct packed {
    ee_pkg::ee_link_state_t state;
    logic [4:0]             cnt;      // Bit counter within a phase
    logic [8:0]             hdr;      // Opcode and address bits
    logic [15:0]            dat;      // Write data bits
    logic [15:0]            outSh;    // Read word being shifted
    logic [4:0]             outLeft;  // Read bits still to send
    logic                   doBit;    // Current output bit
    logic                   readAct;  // Output phase running
    logic                   strapS1;  // Strap synchroniser, first stage
    logic                   strapS2;  // Strap synchroniser, second stage
  } ee_frame_t;

  // Link-clock request side; survives deselect so the handshake stays sound
  typedef struct packed {
    logic           reqTgl;
    ee_pkg::ee_cmd_t cmd;
    logic           ackS1;
    logic           ackS2;
  } ee_req_t;

  // System-clock state
  typedef struct packed {
    logic                  linkRst;  // Holds the link side in reset
    logic                  selS1, selS2, selS3;
    logic                  bitS1, bitS2;
    logic                  actS1, actS2;
    logic                  rqS1, rqS2;
    logic                  ackTgl;
    ee_pkg::ee_cmd_t       ent0;     // Buffer head
    ee_pkg::ee_cmd_t       ent1;     // Buffer tail
    logic [1:0]            fCnt;
    ee_pkg::ee_eng_state_t eng;
    logic [18:0]           progCnt;
    logic                  unlock;   // Program-unlock state
    logic                  progSeen; // A programming cycle was started
    logic                  statArm;  // Ready/busy shown on the output
    logic [7:0]            lowCnt;   // Deselect time counter
    logic                  memWr;
    logic [1:0]            memBe;
    logic [5:0]            memAddr;
    logic [15:0]           memWd;
    logic                  rdX8, rdHi;
    logic [15:0]           rdWord;   // Word handed to the link side
    logic                  dataOut, dataOutEn, progBusy;
  } ee_sys_t;

  localparam logic [18:0] PROG_LAST = 19'(PROG_CYCLES - 1);
  localparam logic [7:0]  DESEL_CYC = 8'(`EE_DESEL_CYC);

  ee_frame_t fr, next_fr;
  ee_req_t   rq, next_rq;
  ee_sys_t   s, next_s;
  logic [15:0] memRd;
  logic        frameClr;
  logic        x8Now;
  logic        hdrX8;
  logic [1:0]  hdrOp;
  logic [6:0]  hdrAddr;
  logic        issue;
  logic [8:0]  hdrNow;   // Header including the bit on the pin at this edge

  // Frame ends on deselect or system reset; partial commands are dropped
  assign frameClr = s.linkRst | ~linkSel;

  // Width in use: fixed variant ignores the strap; floating strap pulled high reads as x16
  assign x8Now = FIXED_X16 ? 1'b0 : ~fr.strapS2;

  // Decode must see the last header bit on its own edge, not one edge late
  assign hdrNow = (fr.state == ee_pkg::EE_LS_HEAD) ? {fr.hdr[7:0], serial_in_pin} : fr.hdr;

  // Link-side decode of the gathered header and next-bit handling
  always_comb begin
    next_fr = fr;
    next_rq = rq;
    hdrX8   = x8Now;
    hdrOp   = 2'h0;
    hdrAddr = 7'h00;
    issue   = 1'b0;
    // Strap passes two flops before use
    next_fr.strapS1 = word_width_strap;
    next_fr.strapS2 = fr.strapS1;
    // Acknowledge toggle synchroniser
    next_rq.ackS1 = s.ackTgl;
    next_rq.ackS2 = rq.ackS1;
    // Full header: x8 has one more address bit
    if (hdrX8) begin
      hdrOp   = hdrNow[8:7];
      hdrAddr = hdrNow[6:0];
    end else begin
      hdrOp   = hdrNow[7:6];
      hdrAddr = {1'b0, hdrNow[5:0]};
    end
    case (fr.state)
      ee_pkg::EE_LS_IDLE: begin
        // Wait for the start bit, sampled on this rising edge
        if (serial_in_pin) begin
          next_fr.state = ee_pkg::EE_LS_HEAD;
          next_fr.cnt   = 5'h00;
        end
      end
      ee_pkg::EE_LS_HEAD: begin
        next_fr.hdr = {fr.hdr[7:0], serial_in_pin};
        next_fr.cnt = fr.cnt + 5'h01;
        if (fr.cnt == (hdrX8 ? `EE_HDR_LAST_X8 : `EE_HDR_LAST_X16)) begin
          next_fr.cnt = 5'h00;
          case (hdrOp)
            `EE_OP_WRITE: begin
              next_fr.state = ee_pkg::EE_LS_DATA;
            end
            `EE_OP_READ: begin
              // Address decoded; fetch word, then dummy clocks
              issue         = 1'b1;
              next_fr.state = ee_pkg::EE_LS_GAP;
            end
            default: begin
              issue         = 1'b1;
              next_fr.state = ee_pkg::EE_LS_DONE;
            end
          endcase
        end
      end
      ee_pkg::EE_LS_DATA: begin
        next_fr.dat = {fr.dat[14:0], serial_in_pin};
        next_fr.cnt = fr.cnt + 5'h01;
        hdrOp       = fr.hdr[hdrX8 ? 8 : 7 -: 2];
        if (fr.cnt == (hdrX8 ? `EE_DAT_LAST_X8 : `EE_DAT_LAST_X16)) begin
          issue         = 1'b1;
          next_fr.state = ee_pkg::EE_LS_DONE;
        end
      end
      ee_pkg::EE_LS_GAP: begin
        // Dummy zero bits while the word is fetched on the system clock
        next_fr.cnt = fr.cnt + 5'h01;
        if (fr.cnt == `EE_GAP_LAST) begin
          next_fr.outSh   = s.rdWord;
          next_fr.doBit   = s.rdWord[15];
          next_fr.outLeft = hdrX8 ? `EE_BITS_X8 : `EE_BITS_X16;
          next_fr.readAct = 1'b1;
          next_fr.state   = ee_pkg::EE_LS_READ;
        end
      end
      ee_pkg::EE_LS_READ: begin
        // Next bit goes out after each rising edge, MSB first
        next_fr.outSh   = {fr.outSh[14:0], 1'b0};
        next_fr.doBit   = fr.outSh[14];
        next_fr.outLeft = fr.outLeft - 5'h01;
        if (fr.outLeft == 5'h01) begin
          next_fr.readAct = 1'b0;
          next_fr.doBit   = 1'b0;
          next_fr.state   = ee_pkg::EE_LS_DONE;
        end
      end
      ee_pkg::EE_LS_DONE: begin
        // Further bits ignored until the next selection
      end
      default: begin
        next_fr.state = ee_pkg::EE_LS_IDLE;
      end
    endcase
    // Hand over only when the previous command was taken; else it is lost
    if (issue && (rq.ackS2 == rq.reqTgl)) begin
      next_rq.reqTgl   = ~rq.reqTgl;
      next_rq.cmd.op   = hdrOp;
      next_rq.cmd.x8   = hdrX8;
      next_rq.cmd.addr = (fr.state == ee_pkg::EE_LS_DATA) ? (hdrX8 ? fr.hdr[6:0] : {1'b0, fr.hdr[5:0]}) : hdrAddr;
      next_rq.cmd.data = next_fr.dat;
    end
  end

  // Frame registers: asynchronous clear when the frame ends
  always_ff @(posedge serial_shift_clock or posedge frameClr) begin
    if (frameClr) begin
      fr <= '{state: ee_pkg::EE_LS_IDLE, default: '0};
    end else begin
      fr <= next_fr;
    end
  end

  // Request registers: cleared by system reset only
  always_ff @(posedge serial_shift_clock or posedge s.linkRst) begin
    if (s.linkRst) begin
      rq <= '0;
    end else begin
      rq <= next_rq;
    end
  end

  // System-side buffer, engine and output stage
  always_comb begin
    logic            take;
    logic            pop;
    ee_pkg::ee_cmd_t hd;
    take   = 1'b0;
    pop    = 1'b0;
    hd     = s.ent0;
    next_s = s;
    next_s.linkRst = 1'b0;
    next_s.memWr   = 1'b0;
    // Two-flop synchronisers for pin and link-side levels
    next_s.selS1 = linkSel;
    next_s.selS2 = s.selS1;
    next_s.selS3 = s.selS2;
    next_s.bitS1 = fr.doBit;
    next_s.bitS2 = s.bitS1;
    next_s.actS1 = fr.readAct;
    next_s.actS2 = s.actS1;
    next_s.rqS1  = rq.reqTgl;
    next_s.rqS2  = s.rqS1;
    // Engine pops the head when idle
    pop = (s.fCnt != 2'h0) && (s.eng == ee_pkg::EE_ES_IDLE);
    case (s.eng)
      ee_pkg::EE_ES_IDLE: begin
        if (pop) begin
          next_s.memAddr = hd.x8 ? hd.addr[6:1] : hd.addr[5:0];
          next_s.memBe   = hd.x8 ? (hd.addr[0] ? `EE_BYTE_HI : `EE_BYTE_LO) : `EE_BYTE_BOTH;
          next_s.rdX8    = hd.x8;
          next_s.rdHi    = hd.addr[0];
          case (hd.op)
            `EE_OP_READ: begin
              next_s.eng = ee_pkg::EE_ES_RWAIT;
            end
            `EE_OP_WRITE, `EE_OP_ERASE: begin
              // Locked device leaves memory alone
              if (s.unlock) begin
                next_s.memWr    = 1'b1;
                next_s.memWd    = (hd.op == `EE_OP_ERASE) ? `EE_ERASED_WORD
                                  : (hd.x8 ? {hd.data[7:0], hd.data[7:0]} : hd.data);
                next_s.progCnt  = 19'h00000;
                next_s.progSeen = 1'b1;
                next_s.eng      = ee_pkg::EE_ES_PROG;
              end
            end
            default: begin
              if (hd.addr[5:4] == `EE_SUB_UNLOCK && !hd.x8 || hd.addr[6:5] == `EE_SUB_UNLOCK && hd.x8) begin
                next_s.unlock = 1'b1;
              end else if (hd.addr[5:4] == `EE_SUB_LOCK && !hd.x8 || hd.addr[6:5] == `EE_SUB_LOCK && hd.x8) begin
                next_s.unlock = 1'b0;
              end
            end
          endcase
        end
      end
      ee_pkg::EE_ES_RWAIT: begin
        // Read data appears one cycle after the address register
        next_s.eng = ee_pkg::EE_ES_RTAKE;
      end
      ee_pkg::EE_ES_RTAKE: begin
        next_s.rdWord = !s.rdX8 ? memRd : {(s.rdHi ? memRd[15:8] : memRd[7:0]), `EE_ZERO_BYTE};
        next_s.eng    = ee_pkg::EE_ES_IDLE;
      end
      ee_pkg::EE_ES_PROG: begin
        // Self-timed; no link clocks needed
        next_s.progCnt = s.progCnt + 19'h00001;
        if (s.progCnt == PROG_LAST) begin
          next_s.eng = ee_pkg::EE_ES_IDLE;
        end
      end
      default: begin
        next_s.eng = ee_pkg::EE_ES_IDLE;
      end
    endcase
    // Two-entry buffer: take a new command only when there is room
    take = (s.rqS2 != s.ackTgl) && (s.fCnt != `EE_FIFO_DEPTH || pop);
    if (pop) begin
      next_s.ent0 = s.ent1;
    end
    if (take) begin
      next_s.ackTgl = ~s.ackTgl;
      if ((s.fCnt == 2'h0) || (s.fCnt == 2'h1 && pop)) begin
        next_s.ent0 = rq.cmd;
      end else begin
        next_s.ent1 = rq.cmd;
      end
    end
    next_s.fCnt = s.fCnt + {1'b0, take} - {1'b0, pop};
    // Deselect time measured while select is low
    if (!s.selS2) begin
      if (s.lowCnt != DESEL_CYC) begin
        next_s.lowCnt = s.lowCnt + 8'h01;
      end
    end else begin
      next_s.lowCnt = 8'h00;
    end
    // Status shown after a long enough deselect once programming started
    if (s.selS2 && !s.selS3 && (s.lowCnt == DESEL_CYC) && s.progSeen) begin
      next_s.statArm = 1'b1;
    end
    if (!s.selS2) begin
      next_s.statArm = 1'b0;
      // A programming start in this same cycle wins over the clear
      if (s.statArm && s.eng != ee_pkg::EE_ES_PROG && next_s.eng != ee_pkg::EE_ES_PROG) begin
        next_s.progSeen = 1'b0;
      end
    end
    // Output pin: floats when deselected; low while busy, high when ready
    next_s.progBusy  = (next_s.eng == ee_pkg::EE_ES_PROG);
    // Only the synchronised select is used; the raw pin never reaches this flop
    next_s.dataOutEn = s.selS2 && (s.actS2 || s.statArm);
    next_s.dataOut   = s.actS2 ? s.bitS2 : (s.statArm && !next_s.progBusy);
  end

  // System-clock registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s <= '{eng: ee_pkg::EE_ES_IDLE, linkRst: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Word store
  ee_word_mem u_mem (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .wrEn    (s.memWr),
    .byteEn  (s.memBe),
    .addr    (s.memAddr),
    .wrData  (s.memWd),
    .rdData  (memRd)
  );

  assign dataOut   = s.dataOut;
  assign dataOutEn = s.dataOutEn;
  assign progBusy  = s.progBusy;

endmodule

/* File: test/ee_serial_checker.sv */
/*
  Checker for the serial slave pins, bound to the slave's top module.
  Assumes select and outputs are sampled on clk_sys.
*/
`timescale 1ns/100ps

module ee_serial_checker #(
  parameter int unsigned PROG_CYCLES = 200  // Programming time in clk_sys cycles
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic serial_shift_clock,
  input wire logic linkSel,
  input wire logic serial_in_pin,
  input wire logic word_width_strap,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic progBusy
);
  logic [15:0] busyCnt;  // Cycles spent programming so far
  logic [5:0]  selAge;   // Cycles since select was last seen high

  // Counters for windows too long to unroll
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busyCnt <= 16'h0000;
      selAge  <= 6'h3F;
    end else begin
      busyCnt <= progBusy ? busyCnt + 16'h0001 : 16'h0000;
      selAge  <= linkSel ? 6'h00 : (selAge == 6'h3F ? selAge : selAge + 6'h01);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_float_off; (!linkSel)[*5] |-> !dataOutEn; endproperty
  a_float_off: assert property (p_float_off) else $error("output driven while deselected");
  property p_release; $fell(linkSel) |-> ##[1:5] !dataOutEn; endproperty
  a_release: assert property (p_release) else $error("output not released after deselect");
  property p_drive_sel;
    dataOutEn |-> ($past(linkSel) || $past(linkSel, 2) || $past(linkSel, 3) || $past(linkSel, 4));
  endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("output driven without select");
  property p_busy_len;
    $fell(progBusy) |-> (busyCnt >= PROG_CYCLES - 1) && (busyCnt <= PROG_CYCLES + 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("programming time wrong");
  property p_self_timed; $rose(progBusy) |-> progBusy[*8]; endproperty
  a_self_timed: assert property (p_self_timed) else $error("programming cut short");
  property p_busy_status; ($rose(dataOutEn) && progBusy) |-> !dataOut; endproperty
  a_busy_status: assert property (p_busy_status) else $error("busy status not low");
  property p_ready_status; ($fell(progBusy) && linkSel && dataOutEn) |-> ##[0:4] dataOut; endproperty
  a_ready_status: assert property (p_ready_status) else $error("ready status not high");
  property p_prog_cause; $rose(progBusy) |-> selAge < 6'h14; endproperty
  a_prog_cause: assert property (p_prog_cause) else $error("programming without a selected frame");

  c_prog:   cover property ($rose(progBusy));
  c_ready:  cover property ($fell(progBusy) && dataOutEn);
  c_answer: cover property ($rose(dataOutEn) && !progBusy);
endmodule

bind ee_serial_slave ee_serial_checker #(.PROG_CYCLES(PROG_CYCLES)) i_ee_serial_checker (
  .clk_sys(clk_sys), .resetn(resetn), .serial_shift_clock(serial_shift_clock), .linkSel(linkSel),
  .serial_in_pin(serial_in_pin), .word_width_strap(word_width_strap), .dataOut(dataOut),
  .dataOutEn(dataOutEn), .progBusy(progBusy)
);

/* File: test/ee_link_master.sv */
/*
  Partner model: the master driving select, link clock and serial input.
  Assumes the slave answers within 40 ns of a rising link edge.
*/
`timescale 1ns/100ps

module ee_link_master (
  output logic      linkSel,
  output logic      serial_shift_clock,
  output logic      serial_in_pin,
  input  wire logic dataOut,
  input  wire logic dataOutEn
);
  wire doWire = dataOutEn ? dataOut : 1'bz;  // Pin level; floats when released

  // Idle: deselected, link clock parked low
  initial begin
    linkSel            = 1'b0;
    serial_shift_clock = 1'b0;
    serial_in_pin      = 1'b0;
  end

  // Released input keeps changing so a stale bit never looks like data
  always #10 if (!linkSel) serial_in_pin = ~serial_in_pin;

  task automatic sel(input bit v);
    linkSel <= v;
  endtask

  // One 15 ns link clock; the bit changes at the falling edge
  task automatic bit_out(input logic b);
    serial_in_pin = b;
    #7.5 serial_shift_clock = 1'b1;
    #7.5 serial_shift_clock = 1'b0;
  endtask

  // Whole frame; read edges are slow because the answer lags by up to 30 ns
  task automatic frame(input logic [31:0] bits, input int n, input int nrd, input bit selv,
                       output logic [15:0] rd);
    int i;
    rd      = 16'h0000;
    linkSel = selv;
    #7.5;
    for (i = 0; i < 4; i++) bit_out(1'b0);  // Leading zeros let the strap settle
    for (i = n - 1; i >= 0; i--) bit_out(bits[i]);
    if (nrd > 0) repeat (7) bit_out(1'b0);
    for (i = 0; i < nrd; i++) begin
      #40 serial_shift_clock = 1'b1;
      #40 rd = {rd[14:0], doWire};
      serial_shift_clock = 1'b0;
    end
    #7.5 linkSel = 1'b0;
    #300;                                   // Long deselect so status may follow
  endtask
endmodule

/* File: test/ee_serial_slave_bench.sv */
/*
  Bench for the serial slave, driven through the master model.
  Assumes a shortened programming time and a 15 ns link clock.
*/
`timescale 1ns/100ps
`include "ee_defines.svh"

module ee_serial_slave_bench;
  localparam int unsigned PROG = 200;  // Shortened programming time
  logic        clk_sys;                // System clock
  logic        resetn;                 // Synchronous reset
  logic        strap;                  // Organisation strap level
  logic        sck, linkSel, din;      // Link wires from the master
  logic        dataOut, dataOutEn;     // Output pin pair
  logic        progBusy;               // Programming indication
  logic [15:0] rd;                     // Last word read back
  int          badCount;
  int          checks;

  ee_serial_slave #(.FIXED_X16(1'b0), .PROG_CYCLES(PROG)) i_ee_serial_slave (
    .clk_sys(clk_sys), .resetn(resetn), .serial_shift_clock(sck), .linkSel(linkSel),
    .serial_in_pin(din), .word_width_strap(strap), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .progBusy(progBusy));
  ee_link_master i_ee_link_master (.linkSel(linkSel), .serial_shift_clock(sck), .serial_in_pin(din),
    .dataOut(dataOut), .dataOutEn(dataOutEn));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Watchdog: the tests need about 30 us
  initial begin
    #200000;
    badCount++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Selected frame without read-back
  task automatic fr(input logic [31:0] bits, input int n);
    i_ee_link_master.frame(bits, n, 0, 1'b1, rd);
  endtask

  // Read frame; x16 when nrd is 16, x8 when 8
  task automatic rd_chk(input logic [31:0] bits, input int n, input int nrd, input logic [15:0] exp);
    i_ee_link_master.frame(bits, n, nrd, 1'b1, rd);
    check(rd, exp);
  endtask

  // Status select: low while busy, high when done, within the programming time
  task automatic wait_ready();
    int n;
    i_ee_link_master.sel(1'b1);
    repeat (5) @(posedge clk_sys);
    #1;
    check({14'h0, dataOutEn, dataOut}, 16'h0002);
    for (n = 0; n < PROG + 50 && dataOut !== 1'b1; n++) @(posedge clk_sys);
    check({15'h0, dataOut}, 16'h0001);
    check({15'h0, n <= PROG + 10}, 16'h0001);
    i_ee_link_master.sel(1'b0);
    #300;
  endtask

  // Select after a refused command: no status and no programming
  task automatic no_prog();
    i_ee_link_master.sel(1'b1);
    repeat (6) @(posedge clk_sys);
    #1;
    check({14'h0, dataOutEn, progBusy}, 16'h0000);
    i_ee_link_master.sel(1'b0);
    #300;
  endtask

  task automatic t_write();
    fr({23'h0, 1'b1, `EE_OP_SPECIAL, `EE_SUB_UNLOCK, 4'h0}, 9);
    fr({7'h0, 1'b1, `EE_OP_WRITE, 6'h05, 16'hA5C3}, 25);
    wait_ready();
    rd_chk({23'h0, 1'b1, `EE_OP_READ, 6'h05}, 9, 16, 16'hA5C3);
    fr({7'h0, 1'b1, `EE_OP_WRITE, 6'h05, 16'h5A3C}, 25);
    wait_ready();
    rd_chk({23'h0, 1'b1, `EE_OP_READ, 6'h05}, 9, 16, 16'h5A3C);
    $display("t_write done");
  endtask

  task automatic t_locked();
    fr({23'h0, 1'b1, `EE_OP_SPECIAL, `EE_SUB_LOCK, 4'h0}, 9);
    fr({7'h0, 1'b1, `EE_OP_WRITE, 6'h05, 16'h1234}, 25);
    no_prog();
    rd_chk({23'h0, 1'b1, `EE_OP_READ, 6'h05}, 9, 16, 16'h5A3C);
    fr({23'h0, 1'b1, `EE_OP_SPECIAL, `EE_SUB_UNLOCK, 4'h0}, 9);
    fr({23'h0, 1'b1, `EE_OP_ERASE, 6'h09}, 9);
    wait_ready();
    rd_chk({23'h0, 1'b1, `EE_OP_READ, 6'h09}, 9, 16, 16'hFFFF);
    $display("t_locked done");
  endtask

  // Bits while deselected, then a frame cut short by deselect
  task automatic t_deselect();
    i_ee_link_master.frame({7'h0, 1'b1, `EE_OP_WRITE, 6'h05, 16'h0000}, 25, 0, 1'b0, rd);
    no_prog();
    fr({29'h0, 1'b1, `EE_OP_WRITE}, 3);
    no_prog();
    rd_chk({23'h0, 1'b1, `EE_OP_READ, 6'h05}, 9, 16, 16'h5A3C);
    $display("t_deselect done");
  endtask

  // Byte organisation: high byte of word 5, then both widths read back
  task automatic t_x8();
    @(posedge clk_sys) strap <= 1'b0;
    fr({14'h0, 1'b1, `EE_OP_WRITE, 7'h0B, 8'h96}, 18);
    wait_ready();
    rd_chk({22'h0, 1'b1, `EE_OP_READ, 7'h0B}, 10, 8, 16'h0096);
    rd_chk({22'h0, 1'b1, `EE_OP_READ, 7'h0A}, 10, 8, 16'h003C);
    @(posedge clk_sys) strap <= 1'b1;
    rd_chk({23'h0, 1'b1, `EE_OP_READ, 6'h05}, 9, 16, 16'h963C);
    $display("t_x8 done");
  endtask

  initial begin
    badCount = 0;
    checks   = 0;
    resetn   = 1'b0;
    strap    = 1'b1;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_write();
    t_locked();
    t_deselect();
    t_x8();
    stop_test();
  end
endmodule
